// File: bca_params.svh
// constants of the battery charge accumulator: register map, fields, timing
// assumes a 25 MHz system clock and 32-bit spi frames
`ifndef BCA_PARAMS_SVH
`define BCA_PARAMS_SVH

`define BCA_CLK_KHZ 25000
`define BCA_REG_CTRL 6'h09
`define BCA_REG_SCALE 6'h0a
`define BCA_CTRL_RUN 0
`define BCA_CTRL_RESET 1
`define BCA_CTRL_ACAL 2
`define BCA_CTRL_DCAL_DIS 3
`define BCA_CTRL_DITHER 4
`define BCA_CTRL_FAULT 5
`define BCA_CTRL_COUNT_LSB 8
`define BCA_PRESCALE_RST 15'h0001
`define BCA_MOST_NEG 16'h8000
`define BCA_RESET_NS 40000
`define BCA_RESET_CYCLES ((`BCA_RESET_NS * `BCA_CLK_KHZ) / 1000000)
`define BCA_DEBOUNCE_MS 1000
`define BCA_DEBOUNCE_CYCLES (`BCA_DEBOUNCE_MS * `BCA_CLK_KHZ)
`define BCA_HDR_BITS 8
`define BCA_FRAME_BITS 32

`endif

// File: bca_pkg.sv
// types of the battery charge accumulator
// assumes bca_params.svh for all numeric constants
package bca_pkg;

    typedef enum logic {BCA_IDLE, BCA_CLEAR} bca_phase_e;

    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] sck_s;
        logic [1:0] mosi_s;
        logic [1:0] uv_s;
        logic [1:0] bd_s;
        logic sck_d;
        logic [5:0] bit_cnt;
        logic [31:0] rx;
        logic [23:0] tx;
        logic miso;
        logic run;
        logic acal;
        logic dcal_dis;
        logic dither;
        logic fault;
        logic [14:0] prescale;
        bca_phase_e phase;
        logic [9:0] rst_cnt;
        logic [15:0] count;
        logic signed [15:0] pre;
        logic cal_short;
        logic dig_cal;
        logic dith_o;
        logic conv_run;
    } bca_top_s;

    typedef struct packed {
        logic [24:0] cnt;
        logic hit;
    } bca_deb_s;

endpackage : bca_pkg

// File: bca_debounce.sv
// debouncer: one-cycle pulse once a synchronised level has stayed high
// for CYCLES clocks; assumes the input is already on the system clock
`timescale 1ns/1ps
module bca_debounce
#(
    parameter int CYCLES = 25000000
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic lvl_i,
    output logic hit_o
);
    import bca_pkg::*;

    bca_deb_s st;
    bca_deb_s next_st;

    always_comb
    begin
        next_st = st;
        next_st.hit = 1'b0;
        if (!lvl_i)
        begin
            next_st.cnt = '0;
        end
        else if (st.cnt < 25'(CYCLES))
        begin
            next_st.cnt = st.cnt + 25'd1;
            // fires once, on the last cycle of the held period
            next_st.hit = (st.cnt == 25'(CYCLES - 1));
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign hit_o = st.hit;

endmodule : bca_debounce

// File: bca_top.sv
// battery charge accumulator: spi register slave, prescaler, charge counter,
// self-clearing counter reset and latched fault flag
// assumes converter step strobes on CLK_I and a slow spi clock (< CLK_I/8)
// Summary of operation
// RULE1: a signed 16-bit charge count goes up on one current sign, down on the other, and is readable.
// RULE2: the count moves one step only after count_prescale converter counts have gathered.
// RULE3: count_prescale starts at one after reset so every converter count moves the count.
// RULE4: writing one to counter_reset_bit clears the charge count and all counting logic.
// RULE5: counter_reset_bit clears itself when the reset period of at most 40 us ends.
// RULE6: counter_run_bit starts accumulation and clearing it only pauses, keeping all state.
// RULE7: offset and gain correction stays on unless digital_cal_disable is set.
// RULE8: analog_cal_enable shorts the converter inputs so only the offset accumulates.
// RULE9: dither_enable dithers the converter only while digital correction is on.
// RULE10: a write to the control register returns the latest charge count on the data out line.
// RULE11: count_invalid_flag latches on any fault until software clears it and raises no interrupt.
// RULE12: reaching the most negative code sets count_invalid_flag while counting continues.
// RULE13: main_supply_input below undervoltage_threshold for a full second sets the flag.
// RULE14: battery_detect_sense held high for a full second sets the flag.
// RULE15: software initialises with calibration, sets the scaler, then resets leaving calibration.
// RULE16: software ends analog calibration and computes the offset from the count it read.
// RULE17: the prescale count clears with the charge count and holds while stopped.
`timescale 1ns/1ps
`include "bca_params.svh"
module bca_top
#(
    parameter int DEBOUNCE_CYCLES = `BCA_DEBOUNCE_CYCLES
)
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic SPI_CLK_I,
    input wire logic SPI_CS_N_I,
    input wire logic SPI_MOSI_I,
    output logic SPI_MISO_O,
    input wire logic CONV_STEP_I,
    input wire logic CONV_UP_I,
    input wire logic SUPPLY_LOW_I,
    input wire logic BATT_DETECT_I,
    output logic CAL_SHORT_O,
    output logic DIG_CAL_EN_O,
    output logic DITHER_O,
    output logic CONV_RUN_O
);
    import bca_pkg::*;

    bca_top_s st;
    bca_top_s next_st;
    logic uv_hit;
    logic bd_hit;

    function automatic logic [23:0] reg_read(input logic [5:0] addr,
                                             input bca_top_s s);
        logic [23:0] d;
        d = '0;
        if (addr == `BCA_REG_CTRL)
        begin
            d[`BCA_CTRL_RUN] = s.run;
            d[`BCA_CTRL_RESET] = (s.phase == BCA_CLEAR);
            d[`BCA_CTRL_ACAL] = s.acal;
            d[`BCA_CTRL_DCAL_DIS] = s.dcal_dis;
            d[`BCA_CTRL_DITHER] = s.dither;
            d[`BCA_CTRL_FAULT] = s.fault;
            d[`BCA_CTRL_COUNT_LSB +: 16] = s.count; // RULE1
        end
        else if (addr == `BCA_REG_SCALE)
        begin
            d[14:0] = s.prescale;
        end
        return d;
    endfunction : reg_read

    bca_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_deb_uv
    (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .lvl_i(st.uv_s[1]),
        .hit_o(uv_hit)
    );

    bca_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_deb_bd
    (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .lvl_i(st.bd_s[1]),
        .hit_o(bd_hit)
    );

    always_comb
    begin
        logic [7:0] hdr;
        logic [31:0] frame;
        logic [23:0] wd;
        logic sck_rise;
        logic sck_fall;
        logic fault_clr;
        logic fault_set;
        logic signed [15:0] limit;
        hdr = '0;
        frame = '0;
        wd = '0;
        fault_clr = 1'b0;
        fault_set = 1'b0;
        next_st = st;
        next_st.cs_s = {st.cs_s[0], SPI_CS_N_I};
        next_st.sck_s = {st.sck_s[0], SPI_CLK_I};
        next_st.mosi_s = {st.mosi_s[0], SPI_MOSI_I};
        next_st.uv_s = {st.uv_s[0], SUPPLY_LOW_I};
        next_st.bd_s = {st.bd_s[0], BATT_DETECT_I};
        next_st.sck_d = st.sck_s[1];
        sck_rise = st.sck_s[1] && !st.sck_d;
        sck_fall = !st.sck_s[1] && st.sck_d;
        limit = (st.prescale == '0) ? 16'sd1 : $signed({1'b0, st.prescale});

        // spi slave, mode 0, msb first
        if (st.cs_s[1])
        begin
            next_st.bit_cnt = '0;
            next_st.miso = 1'b0;
        end
        else if (sck_rise)
        begin
            next_st.rx = {st.rx[30:0], st.mosi_s[1]};
            next_st.bit_cnt = st.bit_cnt + 6'd1;
            if (st.bit_cnt == 6'(`BCA_HDR_BITS - 1))
            begin
                hdr = {st.rx[6:0], st.mosi_s[1]};
                // a write to the control register also returns the count
                next_st.tx = reg_read(hdr[6:1], st); // RULE10
            end
            if (st.bit_cnt == 6'(`BCA_FRAME_BITS - 1))
            begin
                frame = {st.rx[30:0], st.mosi_s[1]};
                wd = frame[23:0];
                if (frame[31] && frame[30:25] == `BCA_REG_CTRL)
                begin
                    next_st.run = wd[`BCA_CTRL_RUN]; // RULE6
                    next_st.acal = wd[`BCA_CTRL_ACAL];
                    next_st.dcal_dis = wd[`BCA_CTRL_DCAL_DIS];
                    next_st.dither = wd[`BCA_CTRL_DITHER];
                    fault_clr = wd[`BCA_CTRL_FAULT]; // RULE11
                    if (wd[`BCA_CTRL_RESET])
                    begin
                        next_st.phase = BCA_CLEAR; // RULE4
                        next_st.rst_cnt = '0;
                    end
                end
                else if (frame[31] && frame[30:25] == `BCA_REG_SCALE)
                begin
                    next_st.prescale = wd[14:0]; // RULE2
                end
            end
        end
        else if (sck_fall && st.bit_cnt >= 6'(`BCA_HDR_BITS))
        begin
            next_st.miso = st.tx[23];
            next_st.tx = {st.tx[22:0], 1'b0};
        end

        // counter reset period, then the bit reads back as zero
        unique case (st.phase)
            BCA_IDLE:
            begin
                if (st.run && CONV_STEP_I) // RULE6 RULE17
                begin
                    if (CONV_UP_I && st.pre + 16'sd1 >= limit)
                    begin
                        next_st.pre = '0;
                        next_st.count = st.count + 16'd1; // RULE1 RULE2
                    end
                    else if (!CONV_UP_I && st.pre - 16'sd1 <= -limit)
                    begin
                        next_st.pre = '0;
                        next_st.count = st.count - 16'd1; // RULE1 RULE2
                    end
                    else
                    begin
                        next_st.pre = CONV_UP_I ? st.pre + 16'sd1
                                                : st.pre - 16'sd1;
                    end
                    if (next_st.count == `BCA_MOST_NEG &&
                        st.count != `BCA_MOST_NEG)
                    begin
                        fault_set = 1'b1; // RULE12
                    end
                end
            end
            BCA_CLEAR:
            begin
                next_st.count = '0; // RULE4
                next_st.pre = '0; // RULE17
                next_st.rst_cnt = st.rst_cnt + 10'd1;
                if (st.rst_cnt == 10'(`BCA_RESET_CYCLES - 1))
                begin
                    next_st.phase = BCA_IDLE; // RULE5
                end
            end
        endcase

        if (uv_hit || bd_hit) // RULE13 RULE14
        begin
            fault_set = 1'b1;
        end
        // a new fault wins over a clear in the same cycle
        if (fault_set)
        begin
            next_st.fault = 1'b1; // RULE11
        end
        else if (fault_clr)
        begin
            next_st.fault = 1'b0;
        end

        next_st.cal_short = next_st.acal; // RULE8
        next_st.dig_cal = !next_st.dcal_dis; // RULE7
        next_st.dith_o = next_st.dither && !next_st.dcal_dis; // RULE9
        next_st.conv_run = next_st.run && next_st.phase == BCA_IDLE;
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            st <= '0;
            st.cs_s <= 2'b11;
            st.prescale <= `BCA_PRESCALE_RST; // RULE3
            st.dig_cal <= 1'b1; // RULE7
        end
        else
        begin
            st <= next_st;
        end
    end

    assign SPI_MISO_O = st.miso;
    assign CAL_SHORT_O = st.cal_short;
    assign DIG_CAL_EN_O = st.dig_cal;
    assign DITHER_O = st.dith_o;
    assign CONV_RUN_O = st.conv_run;

endmodule : bca_top

// File: bca_spi_host.sv
// spi host model: 32-bit mode 0 frames, msb first, select high between
// assumes the system clock drives the bit timing, six cycles a half period
`timescale 1ns/1ps
module bca_spi_host
(
    input wire logic clk_i,
    input wire logic miso_i,
    output logic sck_o,
    output logic cs_n_o,
    output logic mosi_o
);
    initial
    begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b1;
    end
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        @(posedge clk_i);
        #1 cs_n_o = 1'b0;
        for (int i = 31; i >= 0; i--)
        begin
            mosi_o = tx[i];
            repeat (6) @(posedge clk_i);
            #1 sck_o = 1'b1;
            rx[i] = miso_i;
            repeat (6) @(posedge clk_i);
            #1 sck_o = 1'b0;
        end
        repeat (6) @(posedge clk_i);
        #1 cs_n_o = 1'b1;
        // released data line must not keep showing the last bit
        mosi_o = ~mosi_o;
        repeat (8) @(posedge clk_i);
    endtask : xfer
endmodule : bca_spi_host

// File: bca_top_props.sv
// assertions on the charge accumulator ports, bound into bca_top
// assumes one clock domain with synchronous active high reset
`timescale 1ns/1ps
module bca_top_props
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic SPI_CLK_I,
    input wire logic SPI_CS_N_I,
    input wire logic SPI_MISO_O,
    input wire logic CAL_SHORT_O,
    input wire logic DIG_CAL_EN_O,
    input wire logic DITHER_O,
    input wire logic CONV_RUN_O
);
    logic [10:0] low_cnt;
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I || CONV_RUN_O)
            low_cnt <= 11'h000;
        else if (low_cnt != 11'h7ff)
            low_cnt <= low_cnt + 11'h001;
    end
    default clocking @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);
    sequence cs_idle;
        SPI_CS_N_I [*8];
    endsequence
    sequence cs_short;
        SPI_CS_N_I [*5];
    endsequence
    rst_vals_a: assert property ($fell(SYS_RST_I) |->
        !CONV_RUN_O && DIG_CAL_EN_O && !DITHER_O && !CAL_SHORT_O)
        else $error("outputs wrong after reset");
    dither_gate_a: assert property (DITHER_O |-> DIG_CAL_EN_O)
        else $error("dither without digital correction");
    miso_idle_a: assert property (cs_short |=> !SPI_MISO_O)
        else $error("data out driven while deselected");
    miso_edge_a: assert property ($changed(SPI_MISO_O) |-> !SPI_CLK_I)
        else $error("data out moved with spi clock high");
    cal_hold_a: assert property (cs_idle |=> $stable(CAL_SHORT_O))
        else $error("input short moved without a write");
    dcal_hold_a: assert property (cs_idle |=>
        $stable({DIG_CAL_EN_O, DITHER_O}))
        else $error("correction moved without a write");
    run_hold_a: assert property (cs_idle ##0 CONV_RUN_O |=> CONV_RUN_O)
        else $error("accumulation stopped without a write");
    run_resume_a: assert property (cs_idle ##0 $rose(CONV_RUN_O) |->
        low_cnt >= 11'd995 && low_cnt <= 11'd1000)
        else $error("reset period length wrong");
endmodule : bca_top_props
bind bca_top bca_top_props u_bca_top_props
(
    .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .SPI_CLK_I(SPI_CLK_I),
    .SPI_CS_N_I(SPI_CS_N_I), .SPI_MISO_O(SPI_MISO_O),
    .CAL_SHORT_O(CAL_SHORT_O), .DIG_CAL_EN_O(DIG_CAL_EN_O),
    .DITHER_O(DITHER_O), .CONV_RUN_O(CONV_RUN_O)
);

// File: bca_top_bench.sv
// self-checking bench of the charge accumulator through its spi registers
// assumes the spi host model makes every register access
`timescale 1ns/1ps
`include "bca_params.svh"
module bca_top_bench;
    logic clk, rst, step, up, sck, cs_n, mosi, miso, cal, dcal, dith, crun;
    logic [1:0] flt;
    logic [31:0] rx;
    int bad_count = 0;
    int comparisons = 0;
    bca_top #(.DEBOUNCE_CYCLES(20)) u_bca_top (.CLK_I(clk), .SYS_RST_I(rst),
        .SPI_CLK_I(sck), .SPI_CS_N_I(cs_n), .SPI_MOSI_I(mosi),
        .SPI_MISO_O(miso), .CONV_STEP_I(step), .CONV_UP_I(up),
        .SUPPLY_LOW_I(flt[0]), .BATT_DETECT_I(flt[1]), .CAL_SHORT_O(cal),
        .DIG_CAL_EN_O(dcal), .DITHER_O(dith), .CONV_RUN_O(crun));
    bca_spi_host u_bca_spi_host (.clk_i(clk), .miso_i(miso), .sck_o(sck),
        .cs_n_o(cs_n), .mosi_o(mosi));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic op(input logic w, input logic [5:0] a, logic [23:0] v);
        u_bca_spi_host.xfer({w, a, 1'b0, v}, rx);
    endtask : op
    task automatic rd(input string n, input logic [23:0] e);
        op(1'b0, `BCA_REG_CTRL, 24'h00_0000);
        chk(n, rx, {8'h00, e});
    endtask : rd
    task automatic steps(input int n, input logic u);
        @(posedge clk);
        #1 step = 1'b1;
        up = u;
        repeat (n) @(posedge clk);
        #1 step = 1'b0;
    endtask : steps
    task automatic pulse(input int i, input int n);
        @(posedge clk);
        #1 flt[i] = 1'b1;
        repeat (n) @(posedge clk);
        #1 flt[i] = 1'b0;
    endtask : pulse
    task automatic t_init;
        rd("ctrl", 24'h00_0000);
        op(1'b0, `BCA_REG_SCALE, 24'h00_0000);
        chk("scale", rx, 32'h0000_0001);
        op(1'b0, 6'h3f, 24'h00_0000);
        chk("unmapped", rx, 32'h0000_0000);
        $display("init done");
    endtask : t_init
    task automatic t_count;
        op(1'b1, `BCA_REG_CTRL, 24'h00_0001);
        steps(5, 1'b1);
        rd("up", 24'h00_0501);
        op(1'b1, `BCA_REG_SCALE, 24'h00_0003);
        steps(2, 1'b1);
        op(1'b1, `BCA_REG_CTRL, 24'h00_0000);
        steps(4, 1'b1);
        op(1'b1, `BCA_REG_CTRL, 24'h00_0001);
        steps(1, 1'b1);
        rd("resume", 24'h00_0601);
        steps(6, 1'b0);
        rd("down", 24'h00_0401);
        steps(2, 1'b1);
        op(1'b1, `BCA_REG_CTRL, 24'h00_0003);
        chk("run in reset", crun, 1'b0);
        rd("cleared", 24'h00_0003);
        repeat (1000) @(posedge clk);
        rd("self clear", 24'h00_0001);
        chk("run after", crun, 1'b1);
        steps(1, 1'b1);
        rd("residue", 24'h00_0001);
        steps(2, 1'b1);
        $display("count done");
    endtask : t_count
    task automatic t_fault;
        op(1'b1, `BCA_REG_SCALE, 24'h00_0001);
        steps(32769, 1'b0);
        rd("wrap", 24'h80_0021);
        steps(1, 1'b0);
        rd("held", 24'h7f_ff21);
        op(1'b1, `BCA_REG_CTRL, 24'h00_0021);
        chk("echo", rx, 32'h007f_ff21);
        rd("clear", 24'h7f_ff01);
        for (int i = 0; i < 2; i++)
        begin
            pulse(i, 10);
            rd("short dip", 24'h7f_ff01);
            pulse(i, 40);
            rd("long dip", 24'h7f_ff21);
            op(1'b1, `BCA_REG_CTRL, 24'h00_0021);
        end
        $display("fault done");
    endtask : t_fault
    task automatic t_cal;
        op(1'b1, `BCA_REG_CTRL, 24'h00_0017);
        chk("cal outs", {cal, dcal, dith}, 3'b111);
        repeat (1000) @(posedge clk);
        steps(4, 1'b1);
        rd("offset", 24'h00_0415);
        op(1'b1, `BCA_REG_SCALE, 24'h00_0002);
        op(1'b1, `BCA_REG_CTRL, 24'h00_0013);
        chk("offset echo", rx, 32'h0000_0415);
        chk("run outs", {cal, dcal, dith}, 3'b011);
        op(1'b1, `BCA_REG_CTRL, 24'h00_0019);
        chk("no dcal", {cal, dcal, dith}, 3'b000);
        $display("cal done");
    endtask : t_cal
    task automatic close_out;
        $display("checks %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    initial
    begin
        rst = 1'b1;
        step = 1'b0;
        up = 1'b0;
        flt = 2'b00;
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        t_init();
        t_count();
        t_fault();
        t_cal();
        close_out();
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        bad_count++;
        close_out();
    end
endmodule : bca_top_bench
